// ### hdl/twims_pkg.sv
package twims_pkg;
	// register byte offsets
	localparam logic [11:0] OFS_EVT_STOPPED = 12'h104;
	localparam logic [11:0] OFS_EVT_RXREADY = 12'h108;
	localparam logic [11:0] OFS_EVT_TXSENT = 12'h11c;
	localparam logic [11:0] OFS_EVT_ERROR = 12'h124;
	localparam logic [11:0] OFS_EVT_BYTEBND = 12'h138;
	localparam logic [11:0] OFS_EVT_SUSPENDED = 12'h148;
	localparam logic [11:0] OFS_SHORTCUTS = 12'h200;
	localparam logic [11:0] OFS_INT_EN_SET = 12'h304;
	localparam logic [11:0] OFS_INT_EN_CLR = 12'h308;
	// reset values
	localparam logic [1:0] RST_SHORTCUTS = 2'h0;
	localparam logic [5:0] RST_INT_EN = 6'h00;
	localparam logic [5:0] RST_FLAGS = 6'h00;
	// shortcut field positions
	localparam int SHORT_BYTE_BOUNDARY_TO_SUSPEND = 0;
	localparam int SHORT_BB_HALT = 1;
	// interrupt enable field positions in the register word
	localparam int IE_STOPPED = 1;
	localparam int IE_RXREADY = 2;
	localparam int IE_TXSENT = 7;
	localparam int IE_ERROR = 9;
	localparam int IE_BYTEBND = 14;
	localparam int IE_SUSPENDED = 18;
	// internal event index order
	localparam int EV_STOPPED = 0;
	localparam int EV_RXREADY = 1;
	localparam int EV_TXSENT = 2;
	localparam int EV_ERROR = 3;
	localparam int EV_BYTEBND = 4;
	localparam int EV_SUSPENDED = 5;
	localparam int NUM_EV = 6;
	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [11:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [11:0] araddr;
		logic arvalid;
		logic rready;
	} twims_axil_req_s;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} twims_axil_rsp_s;

	// engine events, one-cycle pulses
	typedef struct packed {
		logic stopped;
		logic receive_byte_ready;
		logic transmit_byte_sent;
		logic error;
		logic byte_boundary_event;
		logic read_ack_done;
	} twims_evt_s;
endpackage : twims_pkg

// ### hdl/twims_top.sv
`timescale 1ns/1ps
`default_nettype none
module twims_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// register bus
	input wire twims_pkg::twims_axil_req_s bus_i,
	output twims_pkg::twims_axil_rsp_s bus_o,
	// engine side
	input wire twims_pkg::twims_evt_s evt_i,
	input wire logic suspend_task_i,
	input wire logic resume_task_i,
	output logic suspend_task_o,
	output logic halt_task_o,
	output logic irq_o
);
	// byte-lane strobes widened to a bit mask
	function automatic logic [31:0] lane_mask(input logic [3:0] strb);
		lane_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : lane_mask

	// enable vector to register bit positions and back
	function automatic logic [31:0] en_to_word(input logic [5:0] en);
		en_to_word = 32'h0;
		en_to_word[twims_pkg::IE_STOPPED] = en[twims_pkg::EV_STOPPED];
		en_to_word[twims_pkg::IE_RXREADY] = en[twims_pkg::EV_RXREADY];
		en_to_word[twims_pkg::IE_TXSENT] = en[twims_pkg::EV_TXSENT];
		en_to_word[twims_pkg::IE_ERROR] = en[twims_pkg::EV_ERROR];
		en_to_word[twims_pkg::IE_BYTEBND] = en[twims_pkg::EV_BYTEBND];
		en_to_word[twims_pkg::IE_SUSPENDED] = en[twims_pkg::EV_SUSPENDED];
	endfunction : en_to_word

	function automatic logic [5:0] word_to_en(input logic [31:0] w);
		word_to_en = {w[twims_pkg::IE_SUSPENDED], w[twims_pkg::IE_BYTEBND],
			w[twims_pkg::IE_ERROR], w[twims_pkg::IE_TXSENT],
			w[twims_pkg::IE_RXREADY], w[twims_pkg::IE_STOPPED]};
	endfunction : word_to_en

	function automatic int flag_index(input logic [11:0] a);
		case (a)
			twims_pkg::OFS_EVT_STOPPED: flag_index = twims_pkg::EV_STOPPED;
			twims_pkg::OFS_EVT_RXREADY: flag_index = twims_pkg::EV_RXREADY;
			twims_pkg::OFS_EVT_TXSENT: flag_index = twims_pkg::EV_TXSENT;
			twims_pkg::OFS_EVT_ERROR: flag_index = twims_pkg::EV_ERROR;
			twims_pkg::OFS_EVT_BYTEBND: flag_index = twims_pkg::EV_BYTEBND;
			twims_pkg::OFS_EVT_SUSPENDED: flag_index = twims_pkg::EV_SUSPENDED;
			default: flag_index = -1;
		endcase
	endfunction : flag_index

	// bus state
	// one read in flight at most, but a second write can park behind a waiting response; a held slot keeps its ready low
	logic aw_full_q, w_full_q, awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q, rdata_q;
	logic [3:0] wstrb_q;
	// block state
	logic [5:0] flag_q, int_en_q;
	logic [1:0] event_task_shortcuts_q;
	logic susp_pend_q, suspend_task_q, halt_task_q, irq_q;

	// write channel handshakes, address and data in either order
	wire aw_take = bus_i.awvalid & awready_q;
	wire w_take = bus_i.wvalid & wready_q;
	wire wr_do = aw_full_q & w_full_q & ~bvalid_q;
	wire aw_full_d = (aw_full_q | aw_take) & ~wr_do;
	wire w_full_d = (w_full_q | w_take) & ~wr_do;
	// the response waits for bready; words taken meanwhile stay parked
	wire bvalid_d = wr_do | (bvalid_q & ~bus_i.bready);
	wire [31:0] wmask = lane_mask(wstrb_q);
	wire [31:0] wbits = wdata_q & wmask;
	wire wr_flag = wr_do & (flag_index(awaddr_q) >= 0);
	wire [2:0] wr_flag_sel = (flag_index(awaddr_q) >= 0) ? 3'(flag_index(awaddr_q)) : 3'h0;
	// flag and shortcut words live in byte lane 0
	wire wr_flag_lane = wstrb_q[0];
	wire wr_event_task_shortcuts = wr_do & (awaddr_q == twims_pkg::OFS_SHORTCUTS) & wstrb_q[0];
	wire wr_en_set = wr_do & (awaddr_q == twims_pkg::OFS_INT_EN_SET);
	wire wr_en_clr = wr_do & (awaddr_q == twims_pkg::OFS_INT_EN_CLR);
	wire wr_mapped = wr_flag | (awaddr_q == twims_pkg::OFS_SHORTCUTS) | wr_en_set | wr_en_clr;

	// read channel
	wire rd_do = bus_i.arvalid & arready_q;
	wire rvalid_d = rd_do | (rvalid_q & ~bus_i.rready);
	// low address bits dropped, as on the write side
	wire [11:0] ar_word = {bus_i.araddr[11:2], 2'h0};
	wire rd_is_flag = flag_index(ar_word) >= 0;
	// an unmapped word never indexes the flag vector
	wire [2:0] rd_flag_sel = rd_is_flag ? 3'(flag_index(ar_word)) : 3'h0;
	wire rd_is_event_task_shortcuts = ar_word == twims_pkg::OFS_SHORTCUTS;
	wire rd_is_en = (ar_word == twims_pkg::OFS_INT_EN_SET) |
		(ar_word == twims_pkg::OFS_INT_EN_CLR);
	// flag words carry their state in bit 0 only
	wire [31:0] rd_word = rd_is_flag ? {31'h0, flag_q[rd_flag_sel]} :
		rd_is_event_task_shortcuts ? {30'h0, event_task_shortcuts_q} :
		rd_is_en ? en_to_word(int_en_q) : 32'h0;
	wire rd_mapped = rd_is_flag | rd_is_event_task_shortcuts | rd_is_en;

	// shortcuts fire off the byte-boundary pulse
	wire bb_pulse = evt_i.byte_boundary_event;
	wire short_suspend = bb_pulse & event_task_shortcuts_q[twims_pkg::SHORT_BYTE_BOUNDARY_TO_SUSPEND];
	wire short_halt = bb_pulse & event_task_shortcuts_q[twims_pkg::SHORT_BB_HALT];
	wire suspend_req = suspend_task_i | short_suspend;
	// suspend lands only at a read ack, and only if asked for earlier
	wire susp_evt = evt_i.read_ack_done & susp_pend_q;
	// stop or resume drops a pending suspend; a fresh request in that cycle still wins
	wire susp_pend_d = (susp_pend_q & ~susp_evt & ~resume_task_i & ~evt_i.stopped) | suspend_req;

	// hardware events, one bit per flag word
	wire [5:0] hw_set = {susp_evt, bb_pulse, evt_i.error, evt_i.transmit_byte_sent,
		evt_i.receive_byte_ready, evt_i.stopped};
	// software writes the flag word; a same-cycle hardware set still wins
	logic [5:0] sw_flag;
	always_comb begin
		sw_flag = flag_q;
		if (wr_flag && wr_flag_lane) begin
			sw_flag[wr_flag_sel] = wdata_q[0];
		end
	end
	wire [5:0] flag_d = sw_flag | hw_set;
	// only ones in the written word move an enable
	wire [5:0] en_set_bits = wr_en_set ? word_to_en(wbits) : 6'h00;
	wire [5:0] en_clr_bits = wr_en_clr ? word_to_en(wbits) : 6'h00;
	wire [5:0] int_en_d = (int_en_q | en_set_bits) & ~en_clr_bits;
	// next-state terms, so irq moves on the same edge as the registers
	wire irq_d = |(flag_d & int_en_d);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			// readies start high so a request right after reset is taken
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= twims_pkg::RESP_OKAY;
			awaddr_q <= 12'h000;
			wdata_q <= 32'h0;
			wstrb_q <= 4'h0;
		end else begin
			aw_full_q <= aw_full_d;
			w_full_q <= w_full_d;
			awready_q <= ~aw_full_d;
			wready_q <= ~w_full_d;
			bvalid_q <= bvalid_d;
			if (wr_do) begin
				bresp_q <= wr_mapped ? twims_pkg::RESP_OKAY : twims_pkg::RESP_SLVERR;
			end
			if (aw_take) begin
				awaddr_q <= {bus_i.awaddr[11:2], 2'h0};
			end
			if (w_take) begin
				wdata_q <= bus_i.wdata;
				wstrb_q <= bus_i.wstrb;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= twims_pkg::RESP_OKAY;
		end else begin
			arready_q <= ~rvalid_d;
			rvalid_q <= rvalid_d;
			// data is caught at the address handshake and holds while rvalid waits
			if (rd_do) begin
				rdata_q <= rd_word;
				rresp_q <= rd_mapped ? twims_pkg::RESP_OKAY : twims_pkg::RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			flag_q <= twims_pkg::RST_FLAGS;
			int_en_q <= twims_pkg::RST_INT_EN;
			event_task_shortcuts_q <= twims_pkg::RST_SHORTCUTS;
			susp_pend_q <= 1'b0;
			suspend_task_q <= 1'b0;
			halt_task_q <= 1'b0;
			irq_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
			int_en_q <= int_en_d;
			if (wr_event_task_shortcuts) begin
				event_task_shortcuts_q <= wdata_q[1:0];
			end
			susp_pend_q <= susp_pend_d;
			// task outputs are one-cycle pulses straight from flops
			suspend_task_q <= suspend_req;
			halt_task_q <= short_halt;
			irq_q <= irq_d;
		end
	end

	assign bus_o.awready = awready_q;
	assign bus_o.wready = wready_q;
	assign bus_o.bresp = bresp_q;
	assign bus_o.bvalid = bvalid_q;
	assign bus_o.arready = arready_q;
	assign bus_o.rdata = rdata_q;
	assign bus_o.rresp = rresp_q;
	assign bus_o.rvalid = rvalid_q;
	assign suspend_task_o = suspend_task_q;
	assign halt_task_o = halt_task_q;
	assign irq_o = irq_q;
endmodule : twims_top
`default_nettype wire

// ### verif/twims_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module twims_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// watched ports
	input wire twims_pkg::twims_axil_req_s bus_i,
	input wire twims_pkg::twims_axil_rsp_s bus_o,
	input wire twims_pkg::twims_evt_s evt_i,
	input wire logic suspend_task_i,
	input wire logic suspend_task_o,
	input wire logic halt_task_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_wr;
		bus_i.awvalid && bus_o.awready && bus_i.wvalid && bus_o.wready;
	endsequence
	// a response still waiting on bready delays the next one
	sequence s_wr_free;
		s_wr ##0 !(bus_o.bvalid && !bus_i.bready);
	endsequence
	a_wr_answer: assert property (s_wr_free |-> ##2 bus_o.bvalid)
		else $error("late write response");
	a_wr_refuse: assert property (s_wr |=> !bus_o.awready && !bus_o.wready)
		else $error("write slot not closed");
	a_b_hold: assert property (bus_o.bvalid && !bus_i.bready |=> bus_o.bvalid)
		else $error("write response dropped");
	a_rd_answer: assert property (bus_i.arvalid && bus_o.arready |=> bus_o.rvalid)
		else $error("late read data");
	a_rd_hold: assert property (
		bus_o.rvalid && !bus_i.rready |=> bus_o.rvalid && $stable(bus_o.rdata))
		else $error("read data dropped");
	a_halt_src: assert property (halt_task_o |-> $past(evt_i.byte_boundary_event))
		else $error("halt without byte boundary");
	a_susp_src: assert property (
		suspend_task_o |-> $past(evt_i.byte_boundary_event || suspend_task_i))
		else $error("suspend without cause");
	a_susp_task: assert property (suspend_task_i |=> suspend_task_o)
		else $error("suspend request lost");
endmodule : twims_monitor
bind twims_top twims_monitor u_twims_monitor (.clk_i(clk_i), .reset_i(reset_i), .bus_i(bus_i),
	.bus_o(bus_o), .evt_i(evt_i), .suspend_task_i(suspend_task_i),
	.suspend_task_o(suspend_task_o), .halt_task_o(halt_task_o));
`default_nettype wire

// ### verif/twims_engine_model.sv
`timescale 1ns/1ps
`default_nettype none
module twims_engine_model (
	// byte request from the bench
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic rd_i,
	// event pulses
	output var twims_pkg::twims_evt_s evt_o
);
	logic [1:0] st_q = 2'h0;
	logic rd_q = 1'b0;
	// stopped and error never come from here
	always @(posedge clk_i) begin
		evt_o <= '0;
		if (go_i) begin
			st_q <= 2'h1;
			rd_q <= rd_i;
			evt_o.byte_boundary_event <= 1'b1;
		end else if (st_q == 2'h1) begin
			st_q <= 2'h2;
			evt_o.receive_byte_ready <= rd_q;
			evt_o.transmit_byte_sent <= !rd_q;
		end else if (st_q == 2'h2) begin
			st_q <= 2'h0;
			evt_o.read_ack_done <= rd_q;
		end
	end
endmodule : twims_engine_model
`default_nettype wire

// ### verif/test_twims_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks++; if ((e) !== (a)) begin err_total++; \
	$display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_twims_top;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	twims_pkg::twims_axil_req_s req = '0;
	twims_pkg::twims_axil_rsp_s rsp;
	twims_pkg::twims_evt_s evt;
	logic go = 1'b0, rd = 1'b0, sus = 1'b0, res = 1'b0;
	logic rxs = 1'b0, txs = 1'b0;
	logic sus_o, halt_o, irq;
	logic [34:0] q[$];
	logic [34:0] x;
	logic [5:0] en, m;
	int err_total = 0, checks = 0;
	initial forever #20 clk_i = ~clk_i;
	twims_top u_twims_top (.clk_i(clk_i), .reset_i(reset_i), .bus_i(req), .bus_o(rsp),
		.evt_i(evt), .suspend_task_i(sus), .resume_task_i(res), .suspend_task_o(sus_o),
		.halt_task_o(halt_o), .irq_o(irq));
	twims_engine_model u_twims_engine_model (.clk_i(clk_i), .go_i(go), .rd_i(rd), .evt_o(evt));
	// event order: stopped, rx, tx, error, byte boundary, suspended
	function automatic logic [31:0] w(input logic [5:0] v);
		return {13'h0, v[5], 3'h0, v[4], 4'h0, v[3], 1'h0, v[2], 4'h0, v[1], v[0], 1'h0};
	endfunction : w
	task automatic summarize();
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic xfer(input logic r, input logic [11:0] a, input logic [31:0] d,
		input logic [33:0] e);
		int n;
		q.push_back({r, e});
		if (r) begin
			req.araddr <= a;
			req.arvalid <= 1'b1;
			req.rready <= 1'b1;
		end else begin
			req.awaddr <= a;
			req.wdata <= d;
			req.awvalid <= 1'b1;
			req.wvalid <= 1'b1;
			req.bready <= 1'b1;
		end
		for (n = 0; n < 50; n++) begin
			@(posedge clk_i);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			if (rsp.arready) req.arvalid <= 1'b0;
			if (rsp.bvalid || rsp.rvalid) break;
		end
		req.bready <= 1'b0;
		req.rready <= 1'b0;
		if (n == 50) begin
			err_total++;
			summarize();
		end
		// an edge passes so the next call never re-raises a ready just dropped
		@(posedge clk_i);
	endtask : xfer
	// answers are taken off the queue in issue order
	always @(posedge clk_i) begin
		if ((rsp.bvalid && req.bready) || (rsp.rvalid && req.rready)) begin
			x = q.pop_front();
			if (x[34]) `CHK("rdata", x[33:0], {rsp.rresp, rsp.rdata})
			else `CHK("bresp", x[33:32], rsp.bresp)
		end
	end
	initial begin
		void'($urandom(32'hee11e8e8));
		req.wstrb <= 4'hf;
		repeat (6) @(posedge clk_i);
		reset_i <= 1'b0;
		@(posedge clk_i);
		xfer(1'b1, 12'h200, 0, 0);
		xfer(1'b1, 12'h304, 0, 0);
		xfer(1'b1, 12'h308, 0, 0);
		xfer(1'b1, 12'h148, 0, 0);
		xfer(1'b1, 12'h0fc, 0, {twims_pkg::RESP_SLVERR, 32'h0});
		xfer(1'b0, 12'h400, 1, {twims_pkg::RESP_SLVERR, 32'h0});
		en = '0;
		repeat (4) begin
			m = 6'($urandom);
			en |= m;
			xfer(1'b0, 12'h304, w(m), 0);
			xfer(1'b0, 12'h304, 0, 0);
			xfer(1'b1, 12'h304, 0, {2'h0, w(en)});
			m = 6'($urandom);
			en &= ~m;
			xfer(1'b0, 12'h308, w(m), 0);
			xfer(1'b1, 12'h308, 0, {2'h0, w(en)});
		end
		xfer(1'b0, 12'h308, w(6'h3f), 0);
		sus <= 1'b1;
		@(posedge clk_i);
		sus <= 1'b0;
		#1 `CHK("sus_in", 1'b1, sus_o)
		@(posedge clk_i);
		// a stale suspend request would fake the flag, so drop it first
		for (int s = 0; s < 4; s++) begin
			res <= 1'b1;
			@(posedge clk_i);
			res <= 1'b0;
			xfer(1'b0, 12'h200, 32'(s), 0);
			xfer(1'b1, 12'h200, 0, {2'h0, 32'(s)});
			rd <= 1'($urandom);
			go <= 1'b1;
			@(posedge clk_i);
			go <= 1'b0;
			rxs |= rd;
			txs |= !rd;
			@(posedge clk_i);
			#1 `CHK("sus", s[0], sus_o)
			`CHK("halt", s[1], halt_o)
			repeat (3) @(posedge clk_i);
			xfer(1'b1, 12'h148, 0, {33'h0, s[0] & rd});
			xfer(1'b0, 12'h148, 0, 0);
		end
		xfer(1'b1, 12'h108, 0, {33'h0, rxs});
		xfer(1'b1, 12'h11c, 0, {33'h0, txs});
		#1 `CHK("irq_off", 1'b0, irq)
		@(posedge clk_i);
		xfer(1'b0, 12'h304, w(6'h10), 0);
		#1 `CHK("irq_on", 1'b1, irq)
		@(posedge clk_i);
		xfer(1'b0, 12'h138, 0, 0);
		#1 `CHK("irq_clr", 1'b0, irq)
		summarize();
	end
endmodule : test_twims_top
`default_nettype wire
